// >>> hw/rpsb_bank.sv
// Purpose: per-receive-port status register bank, host read side
// Assumes: host register port issues one-cycle read strobes, clk 20 MHz
// Notes:   all registers are read-only; the bank has no write path
//
// Contract
// - each register exists per port; port select chooses the visible copy
// - integer link frequency in MHz reads at the integer register
// - fractional link frequency in 1/256 MHz reads at the fraction register
// - four sensor status registers load from forward-channel status, not software
// - alarm register shows six serializer alarm flags, bits 7:6 zero
// - voltage register shows sensor 1 value in 6:4, sensor 0 in 2:0
// - temperature register shows 3-bit temperature value in bits 2:0
// - video error register mirrors five input error flags in bits 4:0
// - parity upper register returns the count's upper eight bits
// - count restarts at lock detection or at lower-byte read
// - upper byte clears on lower-byte read, not on its own read
// - lower parity register returns low eight bits and clears on read
`timescale 1ns/1ps
`default_nettype none
module rpsb_bank (
    // clock and reset
    input  wire logic                                               clk,
    input  wire logic                                               rst,
    // per-port events from the receivers
    input  wire rpsb_pkg::rpsb_port_in_t [rpsb_pkg::NUM_PORTS-1:0]  port_in,
    // port select from the port select register
    input  wire logic [rpsb_pkg::PORT_IDX_W-1:0]                    port_sel,
    // host register read port
    input  wire logic [7:0]                                         reg_addr,
    input  wire logic                                               reg_rd,
    output logic [7:0]                                              reg_rdata,
    output logic                                                    reg_rvalid,
    output logic                                                    reg_hit
);
    import rpsb_pkg::*;

    // address compare shared by the read mux and the clear-on-read logic
    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] off);
        addr_is = (addr == off);
    endfunction

    rpsb_port_regs_t              regs      [NUM_PORTS];
    rpsb_port_regs_t              next_regs [NUM_PORTS];
    logic [15:0]                  par_count [NUM_PORTS];
    logic [NUM_PORTS-1:0]         lower_read;
    logic [7:0]                   next_rdata;
    logic                         next_rvalid;
    logic                         next_hit;
    rpsb_port_regs_t              sel_regs;
    logic [15:0]                  sel_count;

    // per-port storage and counters
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            // only the selected port's counter sees the read-clear
            assign lower_read[p] = reg_rd && addr_is(reg_addr, OFF_PAR_LOWER)
                                   && (port_sel == PORT_IDX_W'(p));

            // both frequency bytes come from one measurement pulse
            always_comb begin
                next_regs[p] = regs[p];
                if (port_in[p].freq_valid) begin
                    next_regs[p].link_freq_integer  = port_in[p].freq_integer_byte;
                    next_regs[p].link_freq_fraction = port_in[p].freq_fraction_byte;
                end
                if (port_in[p].status_valid) begin
                    next_regs[p].remote = port_in[p].status;
                end
            end

            // register the port copy
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    regs[p] <= '0;
                end else begin
                    regs[p] <= next_regs[p];
                end
            end

            rpsb_parity_counter u_count (
                .clk           (clk),
                .rst           (rst),
                .parity_err    (port_in[p].parity_err),
                .lock_detected (port_in[p].lock_detected),
                .read_clear    (lower_read[p]),
                .count         (par_count[p])
            );
        end
    endgenerate

    // view of the port the host has selected
    assign sel_regs  = regs[port_sel];
    assign sel_count = par_count[port_sel];

    // read mux; reserved bits are padded with zero, writes have no path here
    always_comb begin
        next_rdata  = RST_BYTE;
        next_rvalid = reg_rd;
        next_hit    = 1'b0;
        if (reg_rd) begin
            next_hit = 1'b1;
            if (addr_is(reg_addr, OFF_FREQ_INT)) begin
                next_rdata = sel_regs.link_freq_integer;
            end else if (addr_is(reg_addr, OFF_FREQ_FRAC)) begin
                next_rdata = sel_regs.link_freq_fraction;
            end else if (addr_is(reg_addr, OFF_ALARM)) begin
                next_rdata = {2'h0, sel_regs.remote.alarm};
            end else if (addr_is(reg_addr, OFF_VOLT)) begin
                next_rdata = RST_BYTE;
                next_rdata[VOLT1_LSB +: 3] = sel_regs.remote.remote_vsensor1_value;
                next_rdata[VOLT0_LSB +: 3] = sel_regs.remote.remote_vsensor0_value;
            end else if (addr_is(reg_addr, OFF_TEMP)) begin
                next_rdata = {5'h00, sel_regs.remote.temp_value};
            end else if (addr_is(reg_addr, OFF_VIDEO_ERR)) begin
                next_rdata = {3'h0, sel_regs.remote.video_err};
            end else if (addr_is(reg_addr, OFF_PAR_UPPER)) begin
                next_rdata = sel_count[15:8];
            end else if (addr_is(reg_addr, OFF_PAR_LOWER)) begin
                next_rdata = sel_count[7:0];
            end else begin
                next_hit = 1'b0; // outside this bank, answer zero
            end
        end
    end

    // read answer registers, one cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata  <= RST_BYTE;
            reg_rvalid <= 1'b0;
            reg_hit    <= 1'b0;
        end else begin
            reg_rdata  <= next_rdata;
            reg_rvalid <= next_rvalid;
            reg_hit    <= next_hit;
        end
    end
endmodule
`default_nettype wire

// >>> hw/rpsb_parity_counter.sv
// Purpose: 16-bit parity error counter for one receive port
// Assumes: error, lock and read-clear inputs are one-cycle pulses
// Notes:   saturates at all ones rather than wrapping
`timescale 1ns/1ps
`default_nettype none
module rpsb_parity_counter (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // events
    input  wire logic        parity_err,
    input  wire logic        lock_detected,
    input  wire logic        read_clear,
    // count
    output logic [15:0]      count
);
    import rpsb_pkg::*;

    logic [15:0] next_count;

    // restart on lock or lower-byte read; a same-cycle error still counts
    always_comb begin
        next_count = count;
        if (lock_detected || read_clear) begin
            next_count = parity_err ? ONE_COUNT : RST_COUNT;
        end else if (parity_err && (count != MAX_COUNT)) begin
            next_count = count + ONE_COUNT; // wrap would fake a small count
        end
    end

    // register the count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= RST_COUNT;
        end else begin
            count <= next_count;
        end
    end
endmodule
`default_nettype wire

// >>> hw/rpsb_pkg.sv
// Purpose: shared constants and types for the receive-port status bank
// Assumes: two receive ports, 8-bit register space, one 20 MHz clock
// Notes:   offsets are the byte addresses seen by the serial host
package rpsb_pkg;

    // port count and the width of the port index
    localparam int          NUM_PORTS  = 2;
    localparam int          PORT_IDX_W = 1;

    // register offsets
    localparam logic [7:0]  OFF_FREQ_INT   = 8'h4f;
    localparam logic [7:0]  OFF_FREQ_FRAC  = 8'h50;
    localparam logic [7:0]  OFF_ALARM      = 8'h51;
    localparam logic [7:0]  OFF_VOLT       = 8'h52;
    localparam logic [7:0]  OFF_TEMP       = 8'h53;
    localparam logic [7:0]  OFF_VIDEO_ERR  = 8'h54;
    localparam logic [7:0]  OFF_PAR_UPPER  = 8'h55;
    localparam logic [7:0]  OFF_PAR_LOWER  = 8'h56;

    // field positions inside the voltage register
    localparam int          VOLT1_LSB = 4;
    localparam int          VOLT0_LSB = 0;

    // reset values, count saturation limit and count step
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] MAX_COUNT = 16'hffff;
    localparam logic [15:0] ONE_COUNT = 16'h0001;

    // alarm flags, bit 5 down to bit 0
    typedef struct packed {
        logic csi_alarm;
        logic remote_backchan_alarm;
        logic link_detect_alarm;
        logic temp_alarm;
        logic remote_vsensor1_alarm;
        logic remote_vsensor0_alarm;
    } rpsb_alarm_t;

    // video input error flags, bit 4 down to bit 0
    typedef struct packed {
        logic remote_header_double_err;
        logic remote_payload_sum_err;
        logic remote_start_tx_err;
        logic remote_sync_err;
        logic remote_control_err;
    } rpsb_video_err_t;

    // status carried in one forward-channel status frame
    typedef struct packed {
        rpsb_alarm_t     alarm;
        logic [2:0]      remote_vsensor1_value;
        logic [2:0]      remote_vsensor0_value;
        logic [2:0]      temp_value;
        rpsb_video_err_t video_err;
    } rpsb_remote_sts_t;

    // per-port events from the link receiver
    typedef struct packed {
        logic             freq_valid;
        logic [7:0]       freq_integer_byte;
        logic [7:0]       freq_fraction_byte;
        logic             status_valid;
        rpsb_remote_sts_t status;
        logic             lock_detected;
        logic             parity_err;
    } rpsb_port_in_t;

    // per-port stored register contents
    typedef struct packed {
        logic [7:0]       link_freq_integer;
        logic [7:0]       link_freq_fraction;
        rpsb_remote_sts_t remote;
    } rpsb_port_regs_t;

endpackage

// >>> tb/rpsb_bank_props.sv
// Purpose: assertions on the status bank read port
// Assumes: single clock, asynchronous active-high reset
// Notes:   watches top ports only; bound after the module
`timescale 1ns/1ps
`default_nettype none
module rpsb_bank_props (
    // clock and reset
    input wire logic                                              clk,
    input wire logic                                              rst,
    // events and host request
    input wire rpsb_pkg::rpsb_port_in_t [rpsb_pkg::NUM_PORTS-1:0] port_in,
    input wire logic [rpsb_pkg::PORT_IDX_W-1:0]                   port_sel,
    input wire logic [7:0]                                        reg_addr,
    input wire logic                                              reg_rd,
    // answer
    input wire logic [7:0]                                        reg_rdata,
    input wire logic                                              reg_rvalid,
    input wire logic                                              reg_hit
);
    import rpsb_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // selected port events and address decode
    wire rpsb_port_in_t sel_ev  = port_in[port_sel];
    wire logic          in_bank = reg_addr inside {[OFF_FREQ_INT:OFF_PAR_LOWER]};
    wire logic          rd_up   = reg_rd && reg_addr == OFF_PAR_UPPER;
    wire logic          rd_low  = reg_rd && reg_addr == OFF_PAR_LOWER;
    // errors in the gap would make a nonzero second answer legal
    sequence s_low_twice;
        (rd_low && !sel_ev.parity_err)
        ##1 (!sel_ev.parity_err && $stable(port_sel))
        ##1 (rd_low && $stable(port_sel));
    endsequence
    sequence s_up_twice;
        (rd_up && !sel_ev.parity_err && !sel_ev.lock_detected)
        ##1 (!sel_ev.parity_err && !sel_ev.lock_detected && !rd_low && $stable(port_sel))
        ##1 (rd_up && $stable(port_sel));
    endsequence
    sequence s_lock_low;
        (sel_ev.lock_detected && !sel_ev.parity_err) ##1 (rd_low && $stable(port_sel));
    endsequence
    AST_ANSWER: assert property (reg_rd |=> reg_rvalid) else $error("no answer");
    AST_QUIET: assert property (!reg_rd |=> !reg_rvalid && !reg_hit && reg_rdata == 8'h00)
        else $error("output without read");
    AST_HIT: assert property (reg_rd |=> reg_hit == $past(in_bank)) else $error("hit wrong");
    AST_UNMAPPED: assert property (reg_rd && !in_bank |=> reg_rdata == 8'h00)
        else $error("unmapped data");
    AST_FRAC: assert property ($stable(port_sel) && $past(sel_ev.freq_valid)
        && reg_rd && reg_addr == OFF_FREQ_FRAC
        |=> reg_rdata == $past(sel_ev.freq_fraction_byte, 2)) else $error("fraction byte");
    AST_VOLT_RSVD: assert property (reg_rd && reg_addr == OFF_VOLT
        |=> !reg_rdata[7] && !reg_rdata[3]) else $error("voltage reserved bits");
    AST_TEMP: assert property ($stable(port_sel) && $past(sel_ev.status_valid)
        && reg_rd && reg_addr == OFF_TEMP
        |=> reg_rdata == {5'h00, $past(sel_ev.status.temp_value, 2)})
        else $error("temperature");
    AST_LOW_CLR: assert property (s_low_twice |=> reg_rdata == 8'h00) else $error("lower kept");
    AST_UP_KEEP: assert property (s_up_twice |=> reg_rdata == $past(reg_rdata, 2))
        else $error("upper cleared by own read");
    AST_LOCK_CLR: assert property (s_lock_low |=> reg_rdata == 8'h00) else $error("lock kept");
endmodule
bind rpsb_bank rpsb_bank_props u_props (.clk, .rst, .port_in, .port_sel, .reg_addr, .reg_rd,
    .reg_rdata, .reg_rvalid, .reg_hit);
`default_nettype wire

// >>> tb/rpsb_link_model.sv
// Purpose: far-side model, link receiver events per port
// Assumes: events are pulses driven at the falling edge
// Notes:   idle value fields show inverted data, never stale values
`timescale 1ns/1ps
`default_nettype none
module rpsb_link_model (
    // clock
    input  wire logic                                         clk,
    // events towards the bank
    output var rpsb_pkg::rpsb_port_in_t [rpsb_pkg::NUM_PORTS-1:0] port_in
);
    import rpsb_pkg::*;
    initial port_in = '0;
    // hold v for n cycles, then drop strobes
    task automatic drive(input int p, input rpsb_port_in_t v, input int n);
        rpsb_port_in_t q;
        q = ~v;
        {q.freq_valid, q.status_valid, q.lock_detected, q.parity_err} = 4'h0;
        @(negedge clk);
        port_in[p] = v;
        repeat (n) @(negedge clk);
        port_in[p] = q;
    endtask
    // both bytes travel in one pulse
    task automatic freq(input int p, input logic [7:0] i, input logic [7:0] f);
        drive(p, {1'b1, i, f, 1'b0, 20'h0_0000, 2'b00}, 1);
    endtask
    // whole status frame replaces all fields
    task automatic status(input int p, input rpsb_remote_sts_t s);
        drive(p, {17'h0_0000, 1'b1, s, 2'b00}, 1);
    endtask
    task automatic lock(input int p);
        drive(p, 40'h00_0000_0002, 1);
    endtask
    task automatic errs(input int p, input int n);
        drive(p, 40'h00_0000_0001, n);
    endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: directed read sequences against the status bank
// Assumes: one read in flight, inputs change at the falling edge
// Notes:   expected bytes built from field positions by hand
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rpsb_pkg::*;
    // design signals and counters
    logic                          clk;
    logic                          rst;
    logic [PORT_IDX_W-1:0]         port_sel;
    logic [7:0]                    reg_addr;
    logic                          reg_rd;
    logic [7:0]                    reg_rdata;
    logic                          reg_rvalid;
    logic                          reg_hit;
    rpsb_port_in_t [NUM_PORTS-1:0] port_in;
    int                            n_fail;
    int                            comparisons;
    rpsb_bank u_dut (.clk, .rst, .port_in, .port_sel, .reg_addr, .reg_rd, .reg_rdata,
        .reg_rvalid, .reg_hit);
    rpsb_link_model u_link (.clk, .port_in);
    // 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // starts at a falling edge, ends at one; answer stands one cycle only
    task automatic rd(input logic [PORT_IDX_W-1:0] p, input logic [7:0] a,
                      input logic [7:0] exp, input string name);
        port_sel = p;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++)
            @(negedge clk);
        if (reg_rvalid !== 1'b1) begin
            n_fail++;
            $display("[ERR] %s rvalid expected 1 seen %b", name, reg_rvalid);
            summarize();
        end
        chk(name, exp, reg_rdata);
        chk({name, " hit"}, {7'h00, a inside {[OFF_FREQ_INT:OFF_PAR_LOWER]}}, {7'h00, reg_hit});
        // idle cycle, so the strobe is never lowered and raised at one instant
        @(negedge clk);
    endtask
    initial begin
        rst = 1'b1;
        port_sel = '0;
        reg_addr = 8'h00;
        reg_rd = 1'b0;
        n_fail = 0;
        comparisons = 0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        // every register of both ports starts at zero
        for (int p = 0; p < NUM_PORTS; p++)
            for (int a = 8'h4f; a <= 8'h56; a++)
                rd(PORT_IDX_W'(p), 8'(a), 8'h00, "reset value");
        $display("test reset done");
        u_link.freq(0, 8'h8c, 8'h40);
        u_link.freq(1, 8'h7a, 8'hc0);
        rd(1, OFF_FREQ_FRAC, 8'hc0, "frac p1");
        rd(1, OFF_FREQ_INT, 8'h7a, "int p1");
        rd(0, OFF_FREQ_INT, 8'h8c, "int p0");
        rd(0, OFF_FREQ_FRAC, 8'h40, "frac p0");
        $display("test frequency done");
        // alarms 100101, v1 110, v0 001, temp 011, video 10010
        // select the port before its load so the load-to-read checks engage
        port_sel = 1'b1;
        u_link.status(1, 20'h9_7172);
        rd(1, OFF_TEMP, 8'h03, "temperature");
        rd(1, OFF_ALARM, 8'h25, "alarms");
        rd(1, OFF_VOLT, 8'h61, "voltages");
        rd(1, OFF_VIDEO_ERR, 8'h12, "video errors");
        rd(0, OFF_ALARM, 8'h00, "other port");
        $display("test status done");
        // errors stop before any count read
        u_link.errs(0, 300);
        rd(0, OFF_PAR_UPPER, 8'h01, "upper");
        rd(0, OFF_PAR_UPPER, 8'h01, "upper again");
        rd(0, OFF_PAR_LOWER, 8'h2c, "lower");
        rd(0, OFF_PAR_LOWER, 8'h00, "lower cleared");
        rd(0, OFF_PAR_UPPER, 8'h00, "upper cleared");
        port_sel = 1'b1;
        u_link.errs(1, 3);
        u_link.lock(1);
        rd(1, OFF_PAR_LOWER, 8'h00, "after lock");
        u_link.errs(1, 2);
        rd(1, OFF_PAR_LOWER, 8'h02, "restart");
        $display("test parity done");
        rd(0, 8'h4e, 8'h00, "below bank");
        rd(1, 8'h57, 8'h00, "above bank");
        $display("test unmapped done");
        summarize();
    end
endmodule
`default_nettype wire
